// >>> rtl/timer_pkg.sv
// Constants and helpers shared by the PWM and phase counting timer
package timer_pkg;

    // ------------------------------------------------------------
    // Structure
    // ------------------------------------------------------------
    localparam int NUM_CH = 3;
    localparam int NUM_GR = 4;
    localparam int CTRL_W = 9;
    localparam int IO_W = 12;
    localparam int IEN_W = 6;

    // ------------------------------------------------------------
    // Register map: byte address = channel * 0x40 + index * 4
    // ------------------------------------------------------------
    localparam logic [3:0] IDX_CTRL = 4'h0;
    localparam logic [3:0] IDX_IOCTL = 4'h1;
    localparam logic [3:0] IDX_STAT = 4'h2;
    localparam logic [3:0] IDX_IEN = 4'h3;
    localparam logic [3:0] IDX_COUNT = 4'h4;
    localparam logic [3:0] IDX_GR_A = 4'h5;
    localparam logic [3:0] IDX_GR_D = 4'h8;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_PHASE_LSB = 2;
    localparam int CTRL_CLR_LSB = 4;
    localparam int CTRL_SYNC_BIT = 7;
    localparam int CTRL_START_BIT = 8;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_PWM1 = 2'h1;
    localparam logic [1:0] MODE_PWM2 = 2'h2;
    localparam logic [1:0] MODE_PHASE = 2'h3;

    localparam logic [1:0] PHASE_M1 = 2'h0;
    localparam logic [1:0] PHASE_M2 = 2'h1;
    localparam logic [1:0] PHASE_M3 = 2'h2;
    localparam logic [1:0] PHASE_M4 = 2'h3;

    localparam logic [2:0] CLR_NONE = 3'h0;
    localparam logic [2:0] CLR_GR_D = 3'h4;
    localparam logic [2:0] CLR_SYNC = 3'h5;

    // ------------------------------------------------------------
    // Output control: three bits per general register
    // ------------------------------------------------------------
    localparam int IO_FIELD_W = 3;
    localparam int IO_INIT_BIT = 2;
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_LOW = 2'h1;
    localparam logic [1:0] ACT_HIGH = 2'h2;
    localparam logic [1:0] ACT_TOGGLE = 2'h3;
    localparam logic [IO_W-1:0] IO_RST = 12'h000;

    // ------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------
    localparam int STAT_OVF_BIT = 4;
    localparam int STAT_UDF_BIT = 5;
    localparam int STAT_DIR_BIT = 6;
    localparam logic DIR_RST = 1'b1;
    localparam logic [IEN_W-1:0] IEN_RST = 6'h00;

    // New pin level after a compare match action
    function automatic logic apply_action(input logic level, input logic [1:0] act);
        unique case (act)
            ACT_NONE: return level;
            ACT_LOW: return 1'b0;
            ACT_HIGH: return 1'b1;
            ACT_TOGGLE: return ~level;
        endcase
    endfunction : apply_action

    // Channel 0 has four general registers, channels 1 and 2 have two
    function automatic logic gr_exists(input int ch, input int gr);
        return (ch == 0) || (gr < 2);
    endfunction : gr_exists

    // Bit mask from Wishbone byte selects
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [31:0] mask);
        return (old_v & ~mask) | (new_v & mask);
    endfunction : merge

endpackage : timer_pkg

// >>> rtl/phase_decoder.sv
// Two-phase encoder input synchroniser and count condition decoder
`timescale 1ns/10ps
module phase_decoder
    import timer_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic phase_a_in,
    input wire logic phase_b_in,
    input wire logic [1:0] phase_mode,
    output logic count_up,
    output logic count_down
);

    logic [1:0] sync1_ff;
    logic [1:0] sync2_ff;
    logic [1:0] prev_ff;
    logic a;
    logic b;
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;

    // ------------------------------------------------------------
    // Synchroniser and edge history
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_ff <= 2'h0;
            sync2_ff <= 2'h0;
            prev_ff <= 2'h0;
        end else begin
            sync1_ff <= {phase_b_in, phase_a_in}; // R24
            sync2_ff <= sync1_ff;
            prev_ff <= sync2_ff;
        end
    end

    assign a = sync2_ff[0];
    assign b = sync2_ff[1];
    assign a_rise = a & ~prev_ff[0]; // R24
    assign a_fall = ~a & prev_ff[0];
    assign b_rise = b & ~prev_ff[1];
    assign b_fall = ~b & prev_ff[1];

    // ------------------------------------------------------------
    // Count conditions
    // ------------------------------------------------------------
    always_comb begin
        unique case (phase_mode)
            PHASE_M1: begin
                count_up = (a & b_fall) | (~a & b_rise) | (b & a_rise) | (~b & a_fall); // R18
                count_down = (a & b_rise) | (~a & b_fall) | (b & a_fall) | (~b & a_rise);
            end
            PHASE_M2: begin
                count_up = a_fall & b; // R19
                count_down = a_rise & ~b;
            end
            PHASE_M3: begin
                count_up = a_fall & b; // R20
                count_down = b_fall & a;
            end
            PHASE_M4: begin
                count_up = (a & b_fall) | (~a & b_rise); // R21
                count_down = (a & b_rise) | (~a & b_fall);
            end
        endcase
    end

endmodule : phase_decoder

// >>> rtl/timer_pwm_quad.sv
// Three-channel timer with PWM modes 1/2 and phase counting, Wishbone slave
//
// Operation
// (R01) Compare match drives pin low, high or toggled.
// (R02) Each channel picks PWM independently; period is the clearing register.
// (R03) PWM1 pairs A with B and C with D, result on A and C pins.
// (R04) PWM1 initial pin level comes from the A or C initial setting.
// (R05) PWM1 pair with equal values leaves pin unchanged.
// (R06) PWM1 gives at most four output phases overall.
// (R07) PWM2 uses one cycle register, others are duty registers.
// (R08) PWM2 counter clear returns every pin to its initial level.
// (R09) PWM2 duty equal to period leaves the pin unchanged.
// (R10) PWM2 with synchronous clearing gives up to seven phases.
// (R11) PWM2 period register pin produces no waveform.
// (R12) PWM1 uses A/C pins only; PWM2 gives each register its pin.
// (R13) Phase counting only on channels 1 and 2, up or down.
// (R14) Phase counting ignores prescaler; clearing, compare, output stay active.
// (R15) Overflow flag on upcount wrap, underflow flag on downcount wrap.
// (R16) Status holds a readable count direction flag.
// (R17) Channel 1 uses inputs A/B, channel 2 uses inputs C/D.
// (R18) Mode 1 counts every edge of both phases.
// (R19) Mode 2 counts only A edges qualified by B level.
// (R20) Mode 3 counts up on A edges, down on B edges.
// (R21) Mode 4 counts only B edges qualified by A level.
// (R22) Counter wraps from all ones to zero and flags overflow.
// (R23) Interrupt request while a flag and its enable are both set.
// (R24) Phase inputs synchronised and edge detected before decoding.
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module timer_pwm_quad
    import timer_pkg::*;
#(
    parameter int COUNT_W = 16
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic ext_clock_in_a,
    input wire logic ext_clock_in_b,
    input wire logic ext_clock_in_c,
    input wire logic ext_clock_in_d,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [NUM_CH*NUM_GR-1:0] capture_compare_pin_out,
    output logic [NUM_CH*NUM_GR-1:0] capture_compare_pin_oe,
    output logic [NUM_CH-1:0] irq_req
);

    if (COUNT_W < 2 || COUNT_W > 16) begin : g_bad_width
        $error("COUNT_W must lie between 2 and 16");
    end

    logic [CTRL_W-1:0] ctrl_ff [NUM_CH];
    logic [IO_W-1:0] io_ff [NUM_CH];
    logic [IEN_W-1:0] ien_ff [NUM_CH];
    logic [3:0] cmp_flag_ff [NUM_CH];
    logic [NUM_CH-1:0] ovf_ff, udf_ff, dir_ff;
    logic [COUNT_W-1:0] count_ff [NUM_CH];
    logic [COUNT_W-1:0] nxt_count [NUM_CH];
    logic [COUNT_W-1:0] gen_ff [NUM_CH][NUM_GR];
    logic [NUM_CH-1:0][NUM_GR-1:0] pin_ff, nxt_pin, oe_ff, nxt_oe, match;
    logic [NUM_CH-1:0] up_t, dn_t, own_clr, clr_all, ovf_ev, udf_ev, q_up, q_dn;
    logic [NUM_CH-1:0] irq_ff;
    logic [31:0] dat_ff, rd_data, wmask;
    logic ack_ff, acc, wr, sync_pulse;
    logic [1:0] a_ch;
    logic [3:0] a_idx;

    // ------------------------------------------------------------
    // Phase decoders, channels 1 and 2 only
    // ------------------------------------------------------------
    assign q_up[0] = 1'b0; // R13
    assign q_dn[0] = 1'b0;
    phase_decoder u_dec1 (
        .clk(clk),
        .rst(rst),
        .phase_a_in(ext_clock_in_a), // R17
        .phase_b_in(ext_clock_in_b),
        .phase_mode(ctrl_ff[1][CTRL_PHASE_LSB +: 2]),
        .count_up(q_up[1]),
        .count_down(q_dn[1])
    );
    phase_decoder u_dec2 (
        .clk(clk),
        .rst(rst),
        .phase_a_in(ext_clock_in_c), // R17
        .phase_b_in(ext_clock_in_d),
        .phase_mode(ctrl_ff[2][CTRL_PHASE_LSB +: 2]),
        .count_up(q_up[2]),
        .count_down(q_dn[2])
    );

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    assign acc = wb_cyc_i & wb_stb_i & ~ack_ff;
    assign wr = acc & wb_we_i;
    assign a_ch = wb_adr_i[7:6];
    assign a_idx = wb_adr_i[5:2];
    assign wmask = lane_mask(wb_sel_i);

    always_comb begin
        rd_data = 32'h0000_0000;
        for (int c = 0; c < NUM_CH; c++) begin
            if (a_ch == 2'(c)) begin
                if (a_idx == IDX_CTRL) rd_data = 32'(ctrl_ff[c]);
                if (a_idx == IDX_IOCTL) rd_data = 32'(io_ff[c]);
                if (a_idx == IDX_STAT) begin
                    rd_data = 32'({dir_ff[c], udf_ff[c], ovf_ff[c], cmp_flag_ff[c]}); // R16
                end
                if (a_idx == IDX_IEN) rd_data = 32'(ien_ff[c]);
                if (a_idx == IDX_COUNT) rd_data = 32'(count_ff[c]);
                for (int g = 0; g < NUM_GR; g++) begin
                    if (a_idx == IDX_GR_A + 4'(g) && gr_exists(c, g)) begin
                        rd_data = 32'(gen_ff[c][g]);
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0000_0000;
        end else begin
            ack_ff <= acc;
            dat_ff <= acc ? rd_data : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Counting, matches and clearing
    // ------------------------------------------------------------
    always_comb begin
        sync_pulse = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            logic run;
            logic [2:0] clr;
            run = ctrl_ff[c][CTRL_START_BIT];
            clr = ctrl_ff[c][CTRL_CLR_LSB +: 3];
            if (ctrl_ff[c][CTRL_MODE_LSB +: 2] == MODE_PHASE && c != 0) begin
                up_t[c] = run & q_up[c]; // R14
                dn_t[c] = run & q_dn[c];
            end else begin
                up_t[c] = run;
                dn_t[c] = 1'b0;
            end
            for (int g = 0; g < NUM_GR; g++) begin
                match[c][g] = (up_t[c] | dn_t[c]) && gr_exists(c, g)
                              && count_ff[c] == gen_ff[c][g];
            end
            own_clr[c] = 1'b0;
            for (int g = 0; g < NUM_GR; g++) begin
                if (clr == 3'(g + 1) && match[c][g]) own_clr[c] = 1'b1; // R02
            end
            if (own_clr[c] && ctrl_ff[c][CTRL_SYNC_BIT]) sync_pulse = 1'b1;
        end
        for (int c = 0; c < NUM_CH; c++) begin
            clr_all[c] = own_clr[c] | (ctrl_ff[c][CTRL_CLR_LSB +: 3] == CLR_SYNC
                          && ctrl_ff[c][CTRL_SYNC_BIT] && sync_pulse); // R10
            ovf_ev[c] = up_t[c] && (&count_ff[c]) && !clr_all[c]; // R22
            udf_ev[c] = dn_t[c] && count_ff[c] == '0 && !clr_all[c]; // R15
            if (clr_all[c]) nxt_count[c] = '0;
            else if (up_t[c]) nxt_count[c] = count_ff[c] + 1'b1; // R22
            else if (dn_t[c]) nxt_count[c] = count_ff[c] - 1'b1;
            else nxt_count[c] = count_ff[c];
        end
    end

    // ------------------------------------------------------------
    // Pin levels and enables
    // ------------------------------------------------------------
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            logic [2:0] clr;
            logic [1:0] mode;
            int per;
            clr = ctrl_ff[c][CTRL_CLR_LSB +: 3];
            mode = ctrl_ff[c][CTRL_MODE_LSB +: 2];
            per = (clr != CLR_NONE && clr <= CLR_GR_D) ? int'(clr) - 1 : NUM_GR;
            nxt_pin[c] = pin_ff[c];
            nxt_oe[c] = '0;
            for (int g = 0; g < NUM_GR; g++) begin
                logic [1:0] act;
                logic init;
                act = io_ff[c][g*IO_FIELD_W +: 2];
                init = io_ff[c][g*IO_FIELD_W + IO_INIT_BIT];
                if (gr_exists(c, g)) begin
                    if (mode == MODE_PWM1) begin
                        if (g % 2 == 0) begin
                            nxt_oe[c][g] = 1'b1; // R12
                            if (!ctrl_ff[c][CTRL_START_BIT]) begin
                                nxt_pin[c][g] = init; // R04
                            end else if (gen_ff[c][g] != gen_ff[c][g+1]) begin // R05
                                if (match[c][g]) nxt_pin[c][g] = apply_action(pin_ff[c][g], act);
                                if (match[c][g+1]) begin // R03
                                    nxt_pin[c][g] = apply_action(pin_ff[c][g],
                                        io_ff[c][(g+1)*IO_FIELD_W +: 2]);
                                end
                            end
                        end
                    end else if (mode == MODE_PWM2) begin
                        nxt_oe[c][g] = (g != per); // R11
                        if (!ctrl_ff[c][CTRL_START_BIT] || clr_all[c]) begin
                            nxt_pin[c][g] = init; // R08
                        end else if (match[c][g] && g != per
                                     && !(per < NUM_GR && gen_ff[c][g] == gen_ff[c][per])) begin
                            nxt_pin[c][g] = apply_action(pin_ff[c][g], act); // R07 R09
                        end
                    end else begin
                        nxt_oe[c][g] = (act != ACT_NONE);
                        if (!ctrl_ff[c][CTRL_START_BIT]) nxt_pin[c][g] = init;
                        else if (match[c][g]) nxt_pin[c][g] = apply_action(pin_ff[c][g], act); // R01
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_ff <= '0;
            oe_ff <= '0;
        end else begin
            pin_ff <= nxt_pin; // R06
            oe_ff <= nxt_oe;
        end
    end

    // ------------------------------------------------------------
    // Configuration and counter registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NUM_CH; c++) begin
                ctrl_ff[c] <= CTRL_RST;
                io_ff[c] <= IO_RST;
                ien_ff[c] <= IEN_RST;
                count_ff[c] <= '0;
                for (int g = 0; g < NUM_GR; g++) gen_ff[c][g] <= '1;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                logic hit;
                hit = wr && a_ch == 2'(c);
                if (hit && a_idx == IDX_CTRL) begin
                    ctrl_ff[c] <= CTRL_W'(merge(32'(ctrl_ff[c]), wb_dat_i, wmask));
                end
                if (hit && a_idx == IDX_IOCTL) begin
                    io_ff[c] <= IO_W'(merge(32'(io_ff[c]), wb_dat_i, wmask));
                end
                if (hit && a_idx == IDX_IEN) begin
                    ien_ff[c] <= IEN_W'(merge(32'(ien_ff[c]), wb_dat_i, wmask));
                end
                if (hit && a_idx == IDX_COUNT) begin
                    count_ff[c] <= COUNT_W'(merge(32'(count_ff[c]), wb_dat_i, wmask));
                end else begin
                    count_ff[c] <= nxt_count[c];
                end
                for (int g = 0; g < NUM_GR; g++) begin
                    if (hit && a_idx == IDX_GR_A + 4'(g) && gr_exists(c, g)) begin
                        gen_ff[c][g] <= COUNT_W'(merge(32'(gen_ff[c][g]), wb_dat_i, wmask));
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Status flags: software writes 0 to clear all but the direction flag, a new event wins
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NUM_CH; c++) cmp_flag_ff[c] <= 4'h0;
            ovf_ff <= '0;
            udf_ff <= '0;
            dir_ff <= {NUM_CH{DIR_RST}};
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                logic [31:0] keep;
                keep = (wr && a_ch == 2'(c) && a_idx == IDX_STAT) ? (wb_dat_i | ~wmask) : '1;
                cmp_flag_ff[c] <= (cmp_flag_ff[c] & keep[3:0]) | match[c];
                ovf_ff[c] <= (ovf_ff[c] & keep[STAT_OVF_BIT]) | ovf_ev[c]; // R15
                udf_ff[c] <= (udf_ff[c] & keep[STAT_UDF_BIT]) | udf_ev[c]; // R15
                if (up_t[c]) dir_ff[c] <= 1'b1; // R16
                else if (dn_t[c]) dir_ff[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_ff <= '0;
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                irq_ff[c] <= |({udf_ff[c], ovf_ff[c], cmp_flag_ff[c]} & ien_ff[c]); // R23
            end
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign capture_compare_pin_out = pin_ff;
    assign capture_compare_pin_oe = oe_ff;
    assign irq_req = irq_ff;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    for (genvar c = 0; c < NUM_CH; c++) begin : g_chk
        chk_ovf_wrap: assert property (@(posedge clk) disable iff (rst) // R22
            ovf_ev[c] && !(wr && a_idx == IDX_COUNT) |=> count_ff[c] == '0 && ovf_ff[c])
            else $error("overflow did not wrap to zero");
        chk_udf_flag: assert property (@(posedge clk) disable iff (rst) // R15
            udf_ev[c] |=> udf_ff[c] && (&count_ff[c] || wr))
            else $error("underflow flag missing");
        chk_dir_track: assert property (@(posedge clk) disable iff (rst) // R16
            dn_t[c] |=> !dir_ff[c] ##0 (up_t[c] or !dir_ff[c]))
            else $error("direction flag wrong");
        chk_pwm2_init: assert property (@(posedge clk) disable iff (rst) // R08
            ctrl_ff[c][1:0] == MODE_PWM2 && clr_all[c] |=>
            pin_ff[c][0] == $past(io_ff[c][IO_INIT_BIT]))
            else $error("PWM2 pin not at initial level after clear");
        chk_pwm1_equal: assert property (@(posedge clk) disable iff (rst) // R05
            ctrl_ff[c][1:0] == MODE_PWM1 && ctrl_ff[c][CTRL_START_BIT]
            && gen_ff[c][0] == gen_ff[c][1] |=> $stable(pin_ff[c][0]))
            else $error("PWM1 pin changed with equal pair");
        chk_pwm1_pins: assert property (@(posedge clk) disable iff (rst) // R12
            ctrl_ff[c][1:0] == MODE_PWM1 |=> !oe_ff[c][1] && !oe_ff[c][3])
            else $error("PWM1 drives a B or D pin");
        chk_period_oe: assert property (@(posedge clk) disable iff (rst) // R11
            ctrl_ff[c][1:0] == MODE_PWM2 && ctrl_ff[c][CTRL_CLR_LSB +: 3] == 3'h2
            |=> !oe_ff[c][1])
            else $error("PWM2 period pin enabled");
        chk_irq_follow: assert property (@(posedge clk) disable iff (rst) // R23
            ovf_ff[c] && ien_ff[c][STAT_OVF_BIT] |=> irq_ff[c])
            else $error("interrupt request missing");
        cov_overflow: cover property (@(posedge clk) disable iff (rst) ovf_ev[c]);
        cov_pwm2_clear: cover property (@(posedge clk) disable iff (rst)
            ctrl_ff[c][1:0] == MODE_PWM2 && clr_all[c]);
        cov_phase_down: cover property (@(posedge clk) disable iff (rst) dn_t[c] ##1 up_t[c]);
    end

    chk_ch0_phase: assert property (@(posedge clk) disable iff (rst) !dn_t[0]) // R13
        else $error("channel 0 counted down");

endmodule : timer_pwm_quad

// >>> test/encoder_model.sv
// Two-phase encoder model driving one quadrature input pair
`timescale 1ns/10ps
module encoder_model (
    input wire logic clk,
    output logic phase_a,
    output logic phase_b
);
    logic [1:0] pos = 2'h0;
    initial begin
        phase_a = 1'b0;
        phase_b = 1'b0;
    end
    // Gray order 00,01,11,10 is one step forward; levels held 4 clocks per step
    task automatic step(input logic up, input int n);
        repeat (n) begin
            pos = up ? pos + 2'h1 : pos - 2'h1;
            phase_a <= pos[1];
            phase_b <= pos[1] ^ pos[0];
            repeat (4) @(posedge clk);
        end
    endtask : step
endmodule : encoder_model

// >>> test/timer_pwm_and_quadrature_modes_tb.sv
// Self-checking bench for the PWM and phase counting timer
`timescale 1ns/10ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module timer_pwm_and_quadrature_modes_tb
    import timer_pkg::*;
;
    logic clk, rst, cyc, stb, we, ack, ext_a, ext_b, ext_c, ext_d, hi_a, lo_a, hi_b, ref_lvl;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, q;
    logic [NUM_CH*NUM_GR-1:0] pin, oe;
    logic [NUM_CH-1:0] irq;
    int err_total = 0;
    int num_checks = 0;
    timer_pwm_quad #(.COUNT_W(16)) dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .ext_clock_in_a(ext_a), .ext_clock_in_b(ext_b), .ext_clock_in_c(ext_c),
        .ext_clock_in_d(ext_d), .wb_dat_o(rdat), .wb_ack_o(ack),
        .capture_compare_pin_out(pin), .capture_compare_pin_oe(oe), .irq_req(irq));
    encoder_model enc1 (.clk(clk), .phase_a(ext_a), .phase_b(ext_b));
    encoder_model enc2 (.clk(clk), .phase_a(ext_c), .phase_b(ext_d));
    // ------------------------------------------------------------
    // Bus access and closing
    // ------------------------------------------------------------
    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
        do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) begin err_total++; conclude(); end
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask : bus
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic check_reset;
        bus(1'b0, 8'h48, 32'h0); `CHK("dir", 1'b1, q[6])
        bus(1'b0, 8'h54, 32'h0); `CHK("gr_a", 32'h0000FFFF, q)
        bus(1'b0, 8'hFC, 32'h0); `CHK("unmapped", 32'h0, q)
    endtask : check_reset
    task automatic check_overflow;
        bus(1'b1, 8'h10, 32'h0000FFFF); bus(1'b1, 8'h0C, 32'h10); bus(1'b1, 8'h00, 32'h100);
        repeat (3) @(posedge clk);
        bus(1'b0, 8'h08, 32'h0); `CHK("ovf", 1'b1, q[4])
        `CHK("irq_set", 1'b1, irq[0])
        bus(1'b1, 8'h00, 32'h0); bus(1'b1, 8'h08, 32'h0);
        repeat (2) @(posedge clk);
        `CHK("irq_clr", 1'b0, irq[0])
    endtask : check_overflow
    task automatic check_phase;
        bus(1'b1, 8'h40, 32'h103); bus(1'b1, 8'h80, 32'h103);
        enc1.step(1'b1, 5);
        bus(1'b0, 8'h50, 32'h0); `CHK("up", 32'h5, q)
        enc1.step(1'b0, 7);
        bus(1'b0, 8'h50, 32'h0); `CHK("down", 32'hFFFE, q)
        bus(1'b0, 8'h48, 32'h0); `CHK("udf", 2'h1, q[6:5])
        enc2.step(1'b1, 3);
        bus(1'b0, 8'h90, 32'h0); `CHK("ch2", 32'h3, q)
    endtask : check_phase
    task automatic check_pwm2;
        bus(1'b1, 8'h10, 32'h0); bus(1'b1, 8'h14, 32'h2); bus(1'b1, 8'h18, 32'h5);
        bus(1'b1, 8'h20, 32'h5); bus(1'b1, 8'h04, 32'h012); bus(1'b1, 8'h00, 32'h142);
        repeat (10) @(posedge clk);
        hi_a = 1'b0; lo_a = 1'b0; hi_b = 1'b0;
        repeat (60) begin
            @(posedge clk);
            hi_a = hi_a | (pin[0] === 1'b1);
            lo_a = lo_a | (pin[0] === 1'b0);
            hi_b = hi_b | (pin[1] === 1'b1);
        end
        `CHK("duty_hi", 1'b1, hi_a)
        `CHK("clr_lo", 1'b1, lo_a)
        `CHK("eq_hold", 1'b0, hi_b)
        `CHK("per_oe", 1'b0, oe[3])
        `CHK("a_oe", 1'b1, oe[0])
    endtask : check_pwm2
    task automatic check_phase_modes;
        bus(1'b1, 8'h80, 32'h10B);
        enc2.step(1'b1, 4);
        bus(1'b0, 8'h90, 32'h0);
        `CHK("m3_down", 32'h2, q)
        enc2.step(1'b0, 8);
        bus(1'b0, 8'h90, 32'h0);
        `CHK("m3_up", 32'h4, q)
        bus(1'b1, 8'h80, 32'h10F);
        enc2.step(1'b1, 4);
        bus(1'b0, 8'h90, 32'h0);
        `CHK("m4_up", 32'h6, q)
        bus(1'b1, 8'h80, 32'h107);
        enc2.step(1'b0, 2);
        bus(1'b0, 8'h90, 32'h0);
        `CHK("m2_a_only", 32'h7, q)
    endtask : check_phase_modes
    task automatic check_pwm1;
        bus(1'b1, 8'h50, 32'h0);
        bus(1'b1, 8'h54, 32'h3);
        bus(1'b1, 8'h58, 32'h1);
        bus(1'b1, 8'h44, 32'h00E);
        bus(1'b1, 8'h40, 32'h011);
        `CHK("pwm1_init", 1'b1, pin[4])
        bus(1'b1, 8'h40, 32'h111);
        hi_a = 1'b0;
        lo_a = 1'b0;
        repeat (20) begin
            @(posedge clk);
            hi_a = hi_a | (lo_a && pin[4] === 1'b1);
            lo_a = lo_a | (pin[4] === 1'b0);
        end
        `CHK("pwm1_rise", 1'b1, hi_a)
        `CHK("pwm1_fall", 1'b1, lo_a)
        `CHK("pwm1_b_oe", 1'b0, oe[5])
        `CHK("pwm1_a_oe", 1'b1, oe[4])
        bus(1'b1, 8'h58, 32'h3);
        @(posedge clk);
        ref_lvl = pin[4];
        hi_b = 1'b0;
        repeat (12) begin
            @(posedge clk);
            hi_b = hi_b | (pin[4] !== ref_lvl);
        end
        `CHK("pwm1_equal", 1'b0, hi_b)
    endtask : check_pwm1
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'hF; wdat = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check_reset();
        check_overflow();
        check_phase();
        check_phase_modes();
        check_pwm2();
        check_pwm1();
        conclude();
    end
endmodule : timer_pwm_and_quadrature_modes_tb
